/* File: move_engine_cfg.svh */
`ifndef MOVE_ENGINE_CFG_SVH
`define MOVE_ENGINE_CFG_SVH

// software register byte offsets
`define OFS_STATUS   8'h00
`define OFS_IRQ_EN   8'h04
`define OFS_IRQ_CLR  8'h08
`define OFS_CTRL     8'h0c
`define OFS_OPHOLD   8'h10
`define OFS_DSADDR   8'h14
`define OFS_COUNT    8'h18
`define OFS_IPTR     8'h1c
`define OFS_FBR      8'h20

// status and enable bit positions
`define ST_ILLEGAL   0
`define ST_DONE      1
`define CTRL_ENABLE  0

// reset values
`define CTRL_RESET   32'h0000_0001
`define IRQ_EN_RESET 2'h0

// instruction word fields and jump pointer step
`define W0_RSVD_HI   29
`define W0_RSVD_LO   24
`define W0_CNT_HI    23
`define JUMP_STEP    32'h0000_0004

// burst depth in words and own register window index of the received byte
`define BURST_WORDS  4
`define FBR_CS_IDX   4'h2

`endif

/* File: move_engine_pkg.sv */
package move_engine_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10,
        ST_FETCH = 2'b11
    } move_state_e;

    typedef struct packed {
        logic [31:0] word0;
        logic [31:0] srcAddr;
        logic [31:0] dstAddr;
    } move_cmd_s;

    typedef struct packed {
        logic [7:0] value;
        logic [7:0] mask;
    } compare_cmd_s;

    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  be;
    } fifo_entry_s;

endpackage

/* File: script_memory_move_engine.sv */
`timescale 1ns/1ps
`include "move_engine_cfg.svh"

module script_memory_move_engine
    import move_engine_pkg::*;
(
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // software register port
    input  wire logic [7:0]   regAddr,
    input  wire logic [31:0]  regWrData,
    input  wire logic         regWr,
    input  wire logic         regRd,
    output logic      [31:0]  regRdData,
    // instruction issue
    input  wire logic         moveValid,
    input  wire move_cmd_s    moveCmd,
    input  wire logic         jumpValid,
    input  wire logic [31:0]  jumpAddr,
    input  wire logic         cmpValid,
    input  wire compare_cmd_s cmpCmd,
    input  wire logic         fbrLoad,
    input  wire logic [7:0]   fbrData,
    output logic              busy,
    output logic              cmpDone,
    output logic              cmpMatch,
    // instruction fetch
    output logic              fetchReq,
    output logic      [31:0]  fetchAddr,
    // system memory master
    output logic              memReq,
    output mem_req_s          memOut,
    input  wire logic [31:0]  memRdData,
    input  wire logic         memAck,
    input  wire logic         memCs,
    // interrupt
    output logic              irq
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    function automatic logic [2:0] beatBytes(input logic [1:0] off, input logic [23:0] cnt);
        logic [2:0] room;
        room = 3'd4 - {1'b0, off};
        beatBytes = (cnt < {21'h0, room}) ? cnt[2:0] : room;
    endfunction

    function automatic logic [3:0] beMask(input logic [1:0] off, input logic [2:0] n);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if ((i >= int'(off)) && (i < int'(off) + int'(n))) begin
                m[i] = 1'b1;
            end
        end
        beMask = m;
    endfunction

    function automatic logic [2:0] beCount(input logic [3:0] be);
        beCount = 3'({2'h0, be[0]} + {2'h0, be[1]} + {2'h0, be[2]} + {2'h0, be[3]});
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    move_state_e  state_q;
    logic [31:0]  opHold_q;
    logic [31:0]  dsAddr_q;
    logic [23:0]  count_q;
    logic [31:0]  ip_q;
    logic [7:0]   fbr_q;
    logic [31:0]  ctrl_q;
    logic [1:0]   status_q;
    logic [1:0]   irqEn_q;
    fifo_entry_s  fifo_q [`BURST_WORDS];
    logic [2:0]   wIdx_q;
    logic [2:0]   rIdx_q;
    logic [31:0]  ownReg_q [16];

    logic         start;
    logic         illegal;
    logic         beatDone;
    logic [31:0]  beatData;
    logic [2:0]   rdBytes;
    logic [23:0]  cntAfter;
    logic         moveDone;

    assign start = moveValid && (state_q == ST_IDLE) && ctrl_q[`CTRL_ENABLE];
    // alignment is checked before any access, so own-register moves get it too
    assign illegal = (moveCmd.word0[`W0_RSVD_HI:`W0_RSVD_LO] != 6'h0) ||
                     (moveCmd.srcAddr[1:0] != moveCmd.dstAddr[1:0]);
    assign beatDone = memReq && (memAck || memCs);
    // own register selected by low address bits when chip select decodes
    assign beatData = memCs ? ownReg_q[memOut.addr[5:2]] : memRdData;
    assign rdBytes  = beatBytes(opHold_q[1:0], count_q);
    assign cntAfter = count_q - {21'h0, rdBytes};
    assign moveDone = (state_q == ST_WRITE) && beatDone && (rIdx_q + 3'd1 == wIdx_q)
                      && (count_q == 24'h0);

    // ------------------------------------------------------------
    // move sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start && !illegal) begin
                        state_q <= (moveCmd.word0[`W0_CNT_HI:0] == 24'h0) ? ST_FETCH : ST_READ;
                    end
                end
                ST_READ: begin
                    // burst fills the buffer, then drains it
                    if (beatDone && (cntAfter == 24'h0 ||
                                     wIdx_q == 3'(`BURST_WORDS - 1))) begin
                        state_q <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (beatDone && rIdx_q + 3'd1 == wIdx_q) begin
                        state_q <= (count_q == 24'h0) ? ST_FETCH : ST_READ;
                    end
                end
                ST_FETCH: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // addresses and count
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            opHold_q <= 32'h0;
            dsAddr_q <= 32'h0;
            count_q  <= 24'h0;
        end else if (start && !illegal) begin
            opHold_q <= moveCmd.srcAddr;
            dsAddr_q <= moveCmd.dstAddr;
            count_q  <= moveCmd.word0[`W0_CNT_HI:0];
        end else if (state_q == ST_READ && beatDone) begin
            opHold_q <= opHold_q + {29'h0, rdBytes};
            count_q  <= cntAfter;
        end else if (state_q == ST_WRITE && beatDone) begin
            dsAddr_q <= dsAddr_q + {29'h0, beCount(memOut.be)};
        end
    end

    // ------------------------------------------------------------
    // burst buffer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wIdx_q <= 3'h0;
            rIdx_q <= 3'h0;
            for (int i = 0; i < `BURST_WORDS; i++) begin
                fifo_q[i] <= '0;
            end
        end else if (state_q == ST_READ && beatDone) begin
            fifo_q[wIdx_q[1:0]] <= '{data: beatData, be: beMask(opHold_q[1:0], rdBytes)};
            wIdx_q <= wIdx_q + 3'd1;
        end else if (state_q == ST_WRITE && beatDone) begin
            if (rIdx_q + 3'd1 == wIdx_q) begin
                wIdx_q <= 3'h0;
                rIdx_q <= 3'h0;
            end else begin
                rIdx_q <= rIdx_q + 3'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // memory master: one beat at a time, one idle cycle between beats
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            memReq <= 1'b0;
            memOut <= '0;
        end else if (beatDone) begin
            memReq <= 1'b0;
        end else if (!memReq && state_q == ST_READ) begin
            memReq <= 1'b1;
            memOut <= '{we: 1'b0, addr: opHold_q,
                        be: beMask(opHold_q[1:0], rdBytes), wdata: 32'h0};
        end else if (!memReq && state_q == ST_WRITE) begin
            memReq <= 1'b1;
            memOut <= '{we: 1'b1, addr: {dsAddr_q[31:2], 2'b00} | {30'h0, dsAddr_q[1:0]},
                        be: fifo_q[rIdx_q[1:0]].be, wdata: fifo_q[rIdx_q[1:0]].data};
        end
    end

    // own register window; the received-byte slot takes no write here
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                ownReg_q[i] <= 32'h0;
            end
        end else if (beatDone && memCs && memOut.we &&
                     memOut.addr[5:2] != `FBR_CS_IDX) begin
            for (int b = 0; b < 4; b++) begin
                if (memOut.be[b]) begin
                    ownReg_q[memOut.addr[5:2]][8*b +: 8] <= memOut.wdata[8*b +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // branch, fetch and compare
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetchReq  <= 1'b0;
            fetchAddr <= 32'h0;
            ip_q      <= 32'h0;
        end else if (state_q == ST_FETCH) begin
            fetchReq  <= 1'b1;
            fetchAddr <= ip_q;
        end else if (jumpValid && state_q == ST_IDLE) begin
            fetchReq  <= 1'b1;
            fetchAddr <= jumpAddr;
            ip_q      <= jumpAddr + `JUMP_STEP;
        end else begin
            fetchReq  <= 1'b0;
        end
    end

    // only the internal load path reaches this register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fbr_q <= 8'h0;
        end else if (fbrLoad) begin
            fbr_q <= fbrData;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmpDone  <= 1'b0;
            cmpMatch <= 1'b0;
        end else begin
            cmpDone <= cmpValid;
            if (cmpValid) begin
                cmpMatch <= ((fbr_q ^ cmpCmd.value) & ~cmpCmd.mask) == 8'h0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_q != ST_IDLE) || (start && !illegal);
        end
    end

    // ------------------------------------------------------------
    // software registers and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= `CTRL_RESET;
            irqEn_q <= `IRQ_EN_RESET;
        end else if (regWr && regAddr == `OFS_CTRL) begin
            ctrl_q  <= regWrData & 32'h0000_0001;
        end else if (regWr && regAddr == `OFS_IRQ_EN) begin
            irqEn_q <= regWrData[1:0];
        end
    end

    // a new event in the clearing cycle stays set
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == `ST_ILLEGAL && start && illegal) ||
                    (i == `ST_DONE && moveDone)) begin
                    status_q[i] <= 1'b1;
                end else if (regWr && regAddr == `OFS_IRQ_CLR && regWrData[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & irqEn_q);
        end
    end

    // reads answer one cycle later; unmapped offsets read zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 32'h0;
        end else if (regRd) begin
            unique case (regAddr)
                `OFS_STATUS: regRdData <= {30'h0, status_q};
                `OFS_IRQ_EN: regRdData <= {30'h0, irqEn_q};
                `OFS_CTRL:   regRdData <= ctrl_q;
                `OFS_OPHOLD: regRdData <= opHold_q;
                `OFS_DSADDR: regRdData <= dsAddr_q;
                `OFS_COUNT:  regRdData <= {8'h0, count_q};
                `OFS_IPTR:   regRdData <= ip_q;
                `OFS_FBR:    regRdData <= {24'h0, fbr_q};
                default:     regRdData <= 32'h0;
            endcase
        end else begin
            regRdData <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_compare_masked: assert property (cmpValid |=> cmpDone &&
        cmpMatch == ((($past(fbr_q) ^ $past(cmpCmd.value)) & ~$past(cmpCmd.mask)) == 8'h0))
        else $error("compare result wrong");
    a_mask_ignores: assert property (cmpValid && cmpCmd.mask == 8'hff |=> cmpMatch)
        else $error("full mask did not match");
    a_jump_pointer: assert property (jumpValid && state_q == ST_IDLE |=>
        fetchReq && fetchAddr == $past(jumpAddr) && ip_q == $past(jumpAddr) + 32'h4)
        else $error("jump pointer wrong");
    a_align_illegal: assert property (start && moveCmd.srcAddr[1:0] != moveCmd.dstAddr[1:0]
        |=> status_q[`ST_ILLEGAL] && state_q == ST_IDLE)
        else $error("misaligned move not refused");
    a_rsvd_illegal: assert property (start && moveCmd.word0[29:24] != 6'h0
        |=> status_q[`ST_ILLEGAL] && !busy)
        else $error("reserved bits not refused");
    a_count_load: assert property (start && !illegal |=>
        count_q == $past(moveCmd.word0[23:0]) && opHold_q == $past(moveCmd.srcAddr))
        else $error("move operands not loaded");
    a_fetch_after: assert property (state_q == ST_FETCH |=> fetchReq && fetchAddr == ip_q)
        else $error("no fetch after move");
    a_fbr_guard: assert property (!fbrLoad |=> fbr_q == $past(fbr_q))
        else $error("received byte changed");
    a_burst_order: assert property (memReq && memOut.we |-> state_q == ST_WRITE)
        else $error("write outside drain");

    c_move_done: cover property (moveDone);
    c_own_reg:   cover property (beatDone && memCs);
    c_illegal:   cover property (start && illegal);

endmodule

/* File: sys_mem_model.sv */
`timescale 1ns/1ps
module sys_mem_model
    import move_engine_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // beat request from the engine
    input  wire logic        memReq,
    input  wire mem_req_s    memOut,
    input  wire logic [3:0]  slow,
    // answer
    output logic      [31:0] memRdData,
    output logic             memAck,
    output logic             memCs
);
    logic [31:0] mem [0:255];
    logic [3:0]  waitCnt;
    logic        own;
    logic [7:0]  idx;

    // top page decodes to the engine's own register window
    assign own = (memOut.addr[31:12] == 20'hfffff);
    assign idx = memOut.addr[9:2];

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            memAck    <= 1'b0;
            memCs     <= 1'b0;
            waitCnt   <= 4'h0;
            memRdData <= 32'h5a5a_a5a5;
        end else begin
            memAck    <= 1'b0;
            memCs     <= 1'b0;
            // no read answered this cycle: toggle so stale data never passes for an answer
            memRdData <= ~memRdData;
            if (memReq && !memAck && !memCs) begin
                if (waitCnt >= slow) begin
                    waitCnt <= 4'h0;
                    if (own) begin
                        memCs <= 1'b1;
                    end else begin
                        memAck <= 1'b1;
                        if (!memOut.we) begin
                            memRdData <= mem[idx];
                        end
                        for (int b = 0; b < 4; b++) begin
                            if (memOut.we && memOut.be[b]) begin
                                mem[idx][8*b +: 8] <= memOut.wdata[8*b +: 8];
                            end
                        end
                    end
                end else begin
                    waitCnt <= waitCnt + 4'h1;
                end
            end
        end
    end
endmodule

/* File: script_memory_move_engine_test.sv */
`timescale 1ns/1ps
`include "move_engine_cfg.svh"
module script_memory_move_engine_test
    import move_engine_pkg::*;
;
    logic         ref_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [7:0]   regAddr;
    logic [31:0]  regWrData;
    logic         regWr, regRd, moveValid, jumpValid, cmpValid, fbrLoad;
    logic [31:0]  regRdData, jumpAddr, fetchAddr, memRdData;
    move_cmd_s    moveCmd;
    compare_cmd_s cmpCmd;
    logic [7:0]   fbrData, f, v, m;
    logic         busy, cmpDone, cmpMatch, fetchReq, memReq, memAck, memCs, irq;
    mem_req_s     memOut;
    logic [3:0]   slow;
    logic [31:0]  rd, ip, s, d, c, lastFetch;
    logic [31:0]  shadow [0:255];
    int           n_errors = 0, comparisons = 0, seed = 87, nFetch, sawBusy;

    always #10 ref_clk = ~ref_clk;

    script_memory_move_engine dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .moveValid(moveValid), .moveCmd(moveCmd), .jumpValid(jumpValid), .jumpAddr(jumpAddr),
        .cmpValid(cmpValid), .cmpCmd(cmpCmd), .fbrLoad(fbrLoad), .fbrData(fbrData),
        .busy(busy), .cmpDone(cmpDone), .cmpMatch(cmpMatch), .fetchReq(fetchReq),
        .fetchAddr(fetchAddr), .memReq(memReq), .memOut(memOut), .memRdData(memRdData),
        .memAck(memAck), .memCs(memCs), .irq(irq));
    sys_mem_model mem_u (.ref_clk(ref_clk), .rst_n(rst_n), .memReq(memReq), .memOut(memOut),
        .slow(slow), .memRdData(memRdData), .memAck(memAck), .memCs(memCs));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        regAddr <= a;
        regWrData <= dat;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] dat);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 dat = regRdData;
        @(posedge ref_clk);
    endtask
    function automatic logic [7:0] sget(input logic [31:0] a);
        return shadow[a[9:2]][8*a[1:0] +: 8];
    endfunction
    function automatic logic [7:0] mget(input logic [31:0] a);
        return mem_u.mem[a[9:2]][8*a[1:0] +: 8];
    endfunction
    // bit by bit on purpose, so the expectation does not mirror the xor form
    function automatic logic matchExp(input logic [7:0] fb, input logic [7:0] val,
                                      input logic [7:0] msk);
        matchExp = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (!msk[i] && fb[i] != val[i]) matchExp = 1'b0;
        end
    endfunction
    // issue one move and follow it until the engine has been idle four cycles
    task automatic move(input logic [31:0] w0, input logic [31:0] sa, input logic [31:0] da);
        int idle;
        idle = 0;
        nFetch = 0;
        sawBusy = 0;
        for (int i = 0; i < 256; i++) shadow[i] = mem_u.mem[i];
        slow <= 4'($random(seed) & 3);
        moveCmd <= '{w0, sa, da};
        moveValid <= 1'b1;
        @(posedge ref_clk);
        moveValid <= 1'b0;
        for (int i = 0; i < 3000 && idle < 4; i++) begin
            #1;
            if (fetchReq === 1'b1) begin
                nFetch++;
                lastFetch = fetchAddr;
            end
            if (busy === 1'b1) sawBusy++;
            idle = (busy === 1'b0) ? idle + 1 : 0;
            @(posedge ref_clk);
        end
        if (idle < 4) begin
            chk(0, 1, "move never ended");
            print_verdict();
        end
    endtask
    task automatic illegal(input logic [31:0] w0, input logic [31:0] sa, input logic [31:0] da);
        move(w0, sa, da);
        chk(nFetch, 0, "illegal move fetched");
        rdr(`OFS_STATUS, rd);
        chk(rd[`ST_ILLEGAL], 1'b1, "illegal flag");
        wr(`OFS_IRQ_CLR, 32'h3);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {regAddr, regWrData, regWr, regRd, moveValid, jumpValid, cmpValid} = '0;
        {moveCmd, jumpAddr, cmpCmd, fbrLoad, fbrData, slow} = '0;
        for (int i = 0; i < 256; i++) mem_u.mem[i] = $random(seed);
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rdr(`OFS_STATUS, rd);  chk(rd, 32'h0, "status reset");
        rdr(`OFS_IRQ_EN, rd);  chk(rd, 32'h0, "irq enable reset");
        rdr(`OFS_CTRL, rd);    chk(rd, `CTRL_RESET, "ctrl reset");
        rdr(8'hfc, rd);        chk(rd, 32'h0, "unmapped read");
        $display("test registers done");

        for (int k = 0; k < 3; k++) begin
            ip = $random(seed) & 32'hffff_fffc;
            jumpAddr <= ip;
            jumpValid <= 1'b1;
            @(posedge ref_clk);
            jumpValid <= 1'b0;
            #1 chk(fetchReq, 1'b1, "jump fetch");
            chk(fetchAddr, ip, "jump target");
            @(posedge ref_clk);
            rdr(`OFS_IPTR, rd);
            chk(rd, ip + `JUMP_STEP, "pointer");
        end
        ip = ip + `JUMP_STEP;
        $display("test jump done");

        // direct source and destination addresses only
        for (int k = 0; k < 12; k++) begin
            c = (k == 0) ? 1 : (k == 1) ? 16 : 1 + ($random(seed) & 31);
            rd = $random(seed) & 3;
            s = ($random(seed) & 32'hfc) | rd;
            d = 32'h200 | ($random(seed) & 32'hfc) | rd;
            move({8'h00, c[23:0]}, s, d);
            chk(sawBusy > 0, 1'b1, "busy");
            for (int b = 0; b < c + 4; b++)
                chk(mget(d + b), (b < c) ? sget(s + b) : sget(d + b), "copied byte");
            chk(nFetch, 1, "fetch count");
            chk(lastFetch, ip, "fetch address");
            rdr(`OFS_OPHOLD, rd);
            chk(rd, s + c, "source held");
            rdr(`OFS_DSADDR, rd);
            chk(rd, d + c, "destination held");
            rdr(`OFS_COUNT, rd);
            chk(rd, 32'h0, "count spent");
            rdr(`OFS_STATUS, rd);
            chk(rd[`ST_DONE], 1'b1, "done flag");
            wr(`OFS_IRQ_CLR, 32'h3);
        end
        move(32'h0, 32'h10, 32'h210);
        chk(nFetch, 1, "zero count fetch");
        $display("test copy done");

        wr(`OFS_IRQ_EN, 32'h1);
        move(32'h4, 32'h11, 32'h212);
        chk(irq, 1'b1, "irq raised");
        wr(`OFS_IRQ_CLR, 32'h1);
        #1 chk(irq, 1'b0, "irq cleared");
        wr(`OFS_IRQ_EN, 32'h0);
        illegal(32'h4, 32'h13, 32'h210);
        chk(irq, 1'b0, "irq masked");
        for (int b = `W0_RSVD_LO; b <= `W0_RSVD_HI; b++)
            illegal((32'h1 << b) | 32'h4, 32'h20, 32'h220);
        wr(`OFS_CTRL, 32'h0);
        move(32'h4, 32'h20, 32'h220);
        chk(sawBusy, 0, "disabled move");
        chk(nFetch, 0, "disabled fetch");
        wr(`OFS_CTRL, `CTRL_RESET);
        $display("test illegal done");

        for (int k = 0; k < 24; k++) begin
            f = 8'($random(seed));
            m = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
            v = k[0] ? f ^ (8'($random(seed)) & m) : 8'($random(seed));
            fbrData <= f;
            fbrLoad <= 1'b1;
            @(posedge ref_clk);
            fbrLoad <= 1'b0;
            cmpCmd <= '{v, m};
            cmpValid <= 1'b1;
            @(posedge ref_clk);
            cmpValid <= 1'b0;
            #1 chk(cmpDone, 1'b1, "compare done");
            chk(cmpMatch, matchExp(f, v, m), "compare result");
            @(posedge ref_clk);
        end
        wr(`OFS_FBR, 32'h0000_0055 ^ f);
        rdr(`OFS_FBR, rd);
        chk(rd[7:0], f, "received byte write");
        $display("test compare done");

        move(32'h4, 32'h40, 32'hffff_f014);
        move(32'h4, 32'hffff_f014, 32'h300);
        chk(mem_u.mem[8'hc0], shadow[8'h10], "own register");
        move(32'h4, 32'h40, 32'hffff_f000 | {`FBR_CS_IDX, 2'b00});
        move(32'h4, 32'hffff_f000 | {`FBR_CS_IDX, 2'b00}, 32'h304);
        chk(mem_u.mem[8'hc1], 32'h0, "received slot");
        rdr(`OFS_FBR, rd);
        chk(rd[7:0], f, "received byte by move");
        illegal(32'h4, 32'hffff_f015, 32'h302);
        $display("test own window done");

        // a count at the 16 MB limit is taken whole; a reset then cuts the move short
        moveCmd <= '{32'h00ff_ffff, 32'h0, 32'h200};
        moveValid <= 1'b1;
        @(posedge ref_clk);
        moveValid <= 1'b0;
        rdr(`OFS_COUNT, rd);
        chk(rd, 32'h00ff_ffff, "full count");
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1 chk(busy, 1'b0, "busy after reset");
        rdr(`OFS_COUNT, rd);
        chk(rd, 32'h0, "count after reset");
        move(32'h4, 32'h44, 32'h344);
        chk(mem_u.mem[8'hd1], shadow[8'h11], "move after reset");
        $display("test reset done");
        print_verdict();
    end
endmodule
